// >>> hw/ilas_cfg_pkg.sv
// constants, register map and mode table for the alignment-sequence configuration generator
// assumes a single core clock domain and an APB register port
`default_nettype none
package ilas_cfg_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CFG_OFS = 8'h04;
  localparam logic [7:0] PARAM_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;
  // reset values
  localparam logic [3:0] FMT_RST = 4'h0;
  localparam logic [7:0] DEV_ID_RST = 8'h00;
  localparam logic [7:0] FPMF_M1_RST = 8'h03;
  // fixed field values
  localparam logic [2:0] JESDV_VAL = 3'h1;
  localparam logic [2:0] SUBCLASSV_VAL = 3'h1;
  localparam logic [9:0] K_EXT_NUM = 10'h100; // 8 x 32 octets per multiblock unit
  // octet positions in one lane's configuration data
  localparam logic [3:0] OCT_DID = 4'h0;
  localparam logic [3:0] OCT_ADJ = 4'h1;
  localparam logic [3:0] OCT_LID = 4'h2;
  localparam logic [3:0] OCT_L = 4'h3;
  localparam logic [3:0] OCT_F = 4'h4;
  localparam logic [3:0] OCT_K = 4'h5;
  localparam logic [3:0] OCT_M = 4'h6;
  localparam logic [3:0] OCT_N = 4'h7;
  localparam logic [3:0] OCT_NP = 4'h8;
  localparam logic [3:0] OCT_S = 4'h9;
  localparam logic [3:0] OCT_HD = 4'ha;
  localparam logic [3:0] OCT_RES1 = 4'hb;
  localparam logic [3:0] OCT_RES2 = 4'hc;
  localparam logic [3:0] OCT_CHK = 4'hd;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } seq_state_t;

  typedef struct packed {
    logic ok;
    logic enc64;
    logic hd;
    logic [3:0] l;
    logic [3:0] m;
    logic [3:0] f;
    logic [2:0] s;
    logic [4:0] n;
    logic [1:0] e;
  } mode_param_t;

  function automatic mode_param_t mk(input logic enc64, input logic hd, input logic [3:0] l,
                                     input logic [3:0] m, input logic [3:0] f,
                                     input logic [2:0] s, input logic [4:0] n,
                                     input logic [1:0] e);
    mk = '{ok: 1'b1, enc64: enc64, hd: hd, l: l, m: m, f: f, s: s, n: n, e: e};
  endfunction

  // one entry per defined link format; all others are flagged invalid
  function automatic mode_param_t mode_lookup(input logic [3:0] sel);
    case (sel)
      4'h0: mode_lookup = mk(1'b0, 1'b0, 4'h8, 4'h8, 4'h8, 3'h5, 5'h0c, 2'h0);
      4'h1: mode_lookup = mk(1'b0, 1'b1, 4'h6, 4'h4, 4'h2, 3'h2, 5'h0c, 2'h0);
      4'h2: mode_lookup = mk(1'b0, 1'b0, 4'h4, 4'h4, 4'h1, 3'h1, 5'h08, 2'h0);
      4'h3: mode_lookup = mk(1'b0, 1'b0, 4'h4, 4'h4, 4'h5, 3'h4, 5'h0a, 2'h0);
      4'h4: mode_lookup = mk(1'b1, 1'b1, 4'h3, 4'h4, 4'h2, 3'h1, 5'h0c, 2'h1);
      4'h5: mode_lookup = mk(1'b1, 1'b0, 4'h2, 4'h4, 4'h2, 3'h1, 5'h08, 2'h1);
      4'h6: mode_lookup = mk(1'b1, 1'b1, 4'h6, 4'h4, 4'h2, 3'h2, 5'h0c, 2'h1);
      4'h7: mode_lookup = mk(1'b1, 1'b0, 4'h4, 4'h4, 4'h1, 3'h1, 5'h08, 2'h1);
      4'h8: mode_lookup = mk(1'b1, 1'b0, 4'h4, 4'h4, 4'h3, 3'h2, 5'h0c, 2'h3);
      4'h9: mode_lookup = mk(1'b0, 1'b0, 4'h8, 4'h4, 4'h1, 3'h2, 5'h08, 2'h0);
      4'ha: mode_lookup = mk(1'b0, 1'b0, 4'h8, 4'h8, 4'h5, 3'h4, 5'h0a, 2'h0);
      4'he: mode_lookup = mk(1'b1, 1'b0, 4'h8, 4'h8, 4'h3, 3'h2, 5'h0c, 2'h3);
      default: mode_lookup = '0;
    endcase
  endfunction
endpackage
`default_nettype wire

// >>> hw/ilas_link_config_generator.sv
// alignment-sequence configuration generator: APB registers, mode decode, per-lane octet stream
// assumes APB master and link layer on core_clk; ilas_start comes from same-clock logic
//
// Operation
// RL1: adjustment amount field always zero
// RL2: adjustment direction field always zero
// RL3: control words, bank id, reserved fields zero
// RL4: control bits per sample reported zero
// RL5: high-density field reported zero
// RL6: device id field from user register
// RL7: frames per multiframe from user register
// RL8: checksum is field sum modulo 256
// RL9: octets per frame from selected mode
// RL10: each active lane gets distinct lane id
// RL11: converter count as dictated by mode
// RL12: bits per sample from selected mode
// RL13: samples per converter from selected mode
// RL14: all derived fields from one selector
// RL15: host selects only defined modes
// RL16: host keeps frame count within mode limits
// RL17: configuration data sent only in 8B/10B
// RL18: no alignment sequence in 64B/66B modes
// RL19: 64B/66B frame count fixed by formula
// RL20: revision and subclass fields equal one
// RL21: scrambler field follows scrambler enable
`default_nettype none
module ilas_link_config_generator
  import ilas_cfg_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ilas_start,
  input wire logic cfg_ready,
  output logic cfg_valid,
  output logic [7:0] cfg_octet,
  output logic [3:0] cfg_index,
  output logic [2:0] cfg_lane,
  output logic cfg_last
);

  logic [3:0] link_format_selector;
  logic scrambler_en;
  logic link_en;
  logic [7:0] device_id;
  logic [7:0] frames_per_multiframe_minus_one;
  mode_param_t mp;
  logic [9:0] k_eff;
  logic [7:0] base_sum;
  seq_state_t state;
  logic setup;
  logic wr_en;
  logic mapped;
  logic [31:0] rd_word;
  logic [3:0] sel_index;
  logic [2:0] sel_lane;
  logic [7:0] sel_octet;
  logic accept;
  logic take_start;
  logic [7:0] l1, f1, m1, n1, s1;
  logic [6:0] sent_cnt;
  logic [6:0] set_len;

  // mode decode: every derived field comes from the one selector
  assign mp = mode_lookup(link_format_selector); // RL14 RL11 RL12 RL13 RL9
  assign l1 = {4'h0, mp.l - 4'h1};
  assign f1 = {4'h0, mp.f - 4'h1};
  assign m1 = {4'h0, mp.m - 4'h1};
  assign n1 = {3'h0, mp.n - 5'h01};
  assign s1 = {5'h0, mp.s - 3'h1};

  // effective frames per multiframe, fixed by formula in 64B/66B formats
  always_comb begin
    if (mp.enc64 && mp.f != 4'h0) begin
      k_eff = (K_EXT_NUM * {8'h00, mp.e}) / {6'h00, mp.f}; // RL19
    end else begin
      k_eff = {2'h0, frames_per_multiframe_minus_one} + 10'h001; // RL7
    end
  end

  // field sum for lane 0; adjustment, bank, cs, hd, cf and reserved add nothing
  assign base_sum = device_id + {7'h00, scrambler_en} + l1 + f1 + frames_per_multiframe_minus_one
                  + m1 + n1 + {5'h00, SUBCLASSV_VAL} + n1 + {5'h00, JESDV_VAL} + s1; // RL8

  // apb decode; zero wait states
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign mapped = paddr[ADDR_W-1:0] == ADDR_W'(CTRL_OFS) || paddr == ADDR_W'(CFG_OFS)
               || paddr == ADDR_W'(PARAM_OFS) || paddr == ADDR_W'(STAT_OFS);

  // control register; format and scrambler frozen while the link runs
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_format_selector <= FMT_RST;
      scrambler_en <= 1'b0;
      link_en <= 1'b0;
    end else if (wr_en && paddr == ADDR_W'(CTRL_OFS) && pstrb[0]) begin
      link_en <= pwdata[5];
      if (!link_en) begin
        link_format_selector <= pwdata[3:0]; // RL14
        scrambler_en <= pwdata[4]; // RL21
      end
    end
  end

  // configuration register; device id and frame count, frozen while the link runs
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      device_id <= DEV_ID_RST;
      frames_per_multiframe_minus_one <= FPMF_M1_RST;
    end else if (wr_en && paddr == ADDR_W'(CFG_OFS) && !link_en) begin
      if (pstrb[0]) begin
        device_id <= pwdata[7:0]; // RL6
      end
      if (pstrb[1]) begin
        frames_per_multiframe_minus_one <= pwdata[15:8]; // RL7
      end
    end
  end

  // read mux
  always_comb begin
    rd_word = 32'h0;
    case (paddr)
      ADDR_W'(CTRL_OFS): rd_word = {26'h0, link_en, scrambler_en, link_format_selector};
      ADDR_W'(CFG_OFS): rd_word = {16'h0, frames_per_multiframe_minus_one, device_id};
      ADDR_W'(PARAM_OFS): rd_word = {4'h0, !mp.ok, mp.enc64, n1[4:0], n1[4:0],
                                     1'b0, s1[2:0], mp.f, mp.m, mp.l};
      ADDR_W'(STAT_OFS): rd_word = {7'h0, state == ST_SEND, base_sum, 6'h0, k_eff};
      default: rd_word = 32'h0;
    endcase
  end

  // read data captured in setup, error flagged on unmapped or read-only write
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= rd_word;
      pslverr <= !mapped || (pwrite && (paddr == ADDR_W'(PARAM_OFS)
                                    || paddr == ADDR_W'(STAT_OFS)));
    end
  end

  // octet assembly for the selected lane and position
  always_comb begin
    sel_octet = 8'h00; // adjustment, bank, hd, cf, reserved stay zero
    case (sel_index)
      OCT_DID: sel_octet = device_id; // RL6
      OCT_ADJ: sel_octet = 8'h00; // RL1 RL3
      OCT_LID: sel_octet = {5'h00, sel_lane}; // RL2 RL10
      OCT_L: sel_octet = {scrambler_en, 2'h0, l1[4:0]}; // RL21
      OCT_F: sel_octet = f1; // RL9
      OCT_K: sel_octet = frames_per_multiframe_minus_one; // RL7
      OCT_M: sel_octet = m1; // RL11
      OCT_N: sel_octet = {3'h0, n1[4:0]}; // RL4 RL12
      OCT_NP: sel_octet = {SUBCLASSV_VAL, n1[4:0]}; // RL20 RL12
      OCT_S: sel_octet = {JESDV_VAL, s1[4:0]}; // RL20 RL13
      OCT_HD: sel_octet = 8'h00; // RL5 RL3
      OCT_RES1: sel_octet = 8'h00; // RL3
      OCT_RES2: sel_octet = 8'h00; // RL3
      OCT_CHK: sel_octet = base_sum + {5'h00, sel_lane}; // RL8
      default: sel_octet = 8'h00;
    endcase
  end

  // start only in an enabled, valid 8B/10B format
  assign take_start = state == ST_IDLE && ilas_start && link_en && mp.ok && !mp.enc64; // RL17 RL18
  assign accept = cfg_valid && cfg_ready;

  // next position in the lane-by-lane walk
  always_comb begin
    sel_index = OCT_DID;
    sel_lane = 3'h0;
    if (state == ST_SEND) begin
      if (cfg_index == OCT_CHK) begin
        sel_lane = cfg_lane + 3'h1; // RL10
      end else begin
        sel_index = cfg_index + 4'h1;
        sel_lane = cfg_lane;
      end
    end
  end

  // sequence state
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: if (take_start) state <= ST_SEND;
        ST_SEND: if (accept && cfg_last) state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // octet stream registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_valid <= 1'b0;
      cfg_octet <= 8'h00;
      cfg_index <= OCT_DID;
      cfg_lane <= 3'h0;
      cfg_last <= 1'b0;
    end else if (take_start || (accept && !cfg_last)) begin
      cfg_valid <= 1'b1;
      cfg_octet <= sel_octet;
      cfg_index <= sel_index;
      cfg_lane <= sel_lane;
      cfg_last <= sel_index == OCT_CHK && {1'b0, sel_lane} == mp.l - 4'h1;
    end else if (accept) begin
      cfg_valid <= 1'b0;
      cfg_last <= 1'b0;
    end
  end

  // whole-set length: fourteen octets for every lane of the format
  assign set_len = ({3'h0, OCT_CHK} + 7'h01) * {3'h0, mp.l}; // RL17

  // octets taken since the last start; read by the length check only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sent_cnt <= 7'h00;
    end else if (take_start) begin
      sent_cnt <= 7'h00;
    end else if (accept) begin
      sent_cnt <= sent_cnt + 7'h01;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_octet(logic [3:0] pos);
    cfg_valid && cfg_index == pos;
  endsequence

  sequence s_start_ok;
    take_start;
  endsequence

  sequence s_last_taken;
    cfg_valid && cfg_ready && cfg_last;
  endsequence

  // fixed fields stay zero
  a_adj_zero: assert property (s_octet(OCT_ADJ) |-> cfg_octet == 8'h00) // RL1
    else $error("adjustment octet not zero");
  a_adjdir_zero: assert property (s_octet(OCT_LID) |-> cfg_octet[7:5] == 3'h0) // RL2
    else $error("adjustment direction not zero");
  a_reserved_zero: assert property (cfg_valid && (cfg_index == OCT_RES1 // RL3
                                    || cfg_index == OCT_RES2) |-> cfg_octet == 8'h00)
    else $error("reserved octet not zero");
  a_cs_zero: assert property (s_octet(OCT_N) |-> cfg_octet[7:6] == 2'h0) // RL4
    else $error("control bits field not zero");
  a_hd_zero: assert property (s_octet(OCT_HD) |-> cfg_octet == 8'h00) // RL5
    else $error("high-density octet not zero");

  // user fields and checksum
  a_did_field: assert property (s_octet(OCT_DID) |-> cfg_octet == device_id) // RL6
    else $error("device id mismatch");
  a_k_field: assert property (s_octet(OCT_K) |-> cfg_octet == k_eff[7:0] - 8'h01) // RL7
    else $error("frame count mismatch");
  a_chk_field: assert property (s_octet(OCT_CHK) // RL8
                                |-> cfg_octet == base_sum + {5'h00, cfg_lane})
    else $error("checksum mismatch");

  // lane walk, start gating and coding-dependent behaviour
  a_lid_walk: assert property (s_octet(OCT_CHK) ##0 (cfg_ready && !cfg_last) // RL10
                               |=> cfg_lane == $past(cfg_lane) + 3'h1
                                   && cfg_index == OCT_DID)
    else $error("lane id not stepped");
  a_rev_one: assert property (s_octet(OCT_S) |-> cfg_octet[7:5] == 3'h1) // RL20
    else $error("revision field not one");
  a_start_runs: assert property (s_start_ok |=> cfg_valid && cfg_index == OCT_DID // RL17
                                 && cfg_lane == 3'h0)
    else $error("sequence did not start");
  a_no_seq_66: assert property (mp.enc64 && state == ST_IDLE |=> !cfg_valid) // RL18
    else $error("sequence sent in 64B/66B format");
  a_k66_fixed: assert property (mp.enc64 // RL19
                                |-> k_eff * {6'h00, mp.f} == K_EXT_NUM * {8'h00, mp.e})
    else $error("64B/66B frame count wrong");
  a_scr_field: assert property (s_octet(OCT_L) |-> cfg_octet[7] == scrambler_en) // RL21
    else $error("scrambler field mismatch");

  // derived fields follow the selected format
  a_f_field: assert property (s_octet(OCT_F) |-> cfg_octet == {4'h0, mp.f - 4'h1}) // RL9
    else $error("octets per frame mismatch");
  a_m_field: assert property (s_octet(OCT_M) |-> cfg_octet == {4'h0, mp.m - 4'h1}) // RL11
    else $error("converter count mismatch");
  a_n_field: assert property (s_octet(OCT_N) |-> cfg_octet[4:0] == mp.n - 5'h01) // RL12
    else $error("resolution field mismatch");
  a_np_field: assert property (s_octet(OCT_NP) // RL12 RL20
                               |-> cfg_octet == {SUBCLASSV_VAL, mp.n - 5'h01})
    else $error("bits per sample field mismatch");
  a_s_field: assert property (s_octet(OCT_S) |-> cfg_octet[4:0] == {2'h0, mp.s - 3'h1}) // RL13
    else $error("samples per frame mismatch");
  a_l_field: assert property (s_octet(OCT_L) |-> cfg_octet[4:0] == {1'b0, mp.l - 4'h1}) // RL14
    else $error("lane count mismatch");
  a_lane_first: assert property (s_octet(OCT_LID) |-> cfg_octet[2:0] == cfg_lane) // RL10
    else $error("lane id octet mismatch");
  a_lane_range: assert property (cfg_valid |-> {1'b0, cfg_lane} < mp.l) // RL10
    else $error("lane id beyond active lanes");

  // the stream holds under back-pressure and ends cleanly
  a_octet_hold: assert property (cfg_valid && !cfg_ready |=> cfg_valid // RL17
                                 && $stable(cfg_octet) && $stable(cfg_index)
                                 && $stable(cfg_lane))
    else $error("octet changed while stalled");
  a_index_range: assert property (cfg_valid |-> cfg_index <= OCT_CHK) // RL17
    else $error("octet position out of range");
  a_set_length: assert property (s_last_taken |-> sent_cnt == set_len - 7'h01) // RL17
    else $error("configuration set length wrong");
  a_end_idle: assert property (s_last_taken |=> !cfg_valid && state == ST_IDLE) // RL17
    else $error("sequence did not end after last octet");
  a_last_lane: assert property (s_last_taken // RL10
                                |-> {1'b0, cfg_lane} == mp.l - 4'h1 && cfg_index == OCT_CHK)
    else $error("last flag on wrong octet");
  a_idle_quiet: assert property (state == ST_IDLE && !take_start |=> !cfg_valid) // RL17 RL18
    else $error("octet sent without accepted start");

  // settings frozen while the link runs
  a_fmt_lock: assert property (link_en |=> $stable(link_format_selector) // RL14 RL21
                               && $stable(scrambler_en))
    else $error("format changed while link enabled");
  a_cfg_lock: assert property (link_en |=> $stable(device_id) // RL6 RL7
                               && $stable(frames_per_multiframe_minus_one))
    else $error("configuration changed while link enabled");

endmodule
`default_nettype wire

// >>> testbench/cfg_sink.sv
// receiver model: takes configuration octets, stalling at random when asked
// assumes the generator's core_clk and arst_n
`default_nettype none
module cfg_sink (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic stall_en,
  output logic cfg_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ready drops about one cycle in three while stalling
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n)
      cfg_ready <= 1'b0;
    else
      cfg_ready <= !stall_en || ($urandom % 3 != 0);
  end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// bench: apb set-up, every 8b/10b format streamed and checked, refused starts
// assumes the generator answers apb with zero wait states
`default_nettype none
module tb_top;
  import ilas_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, e, scr;
  logic ilas_start, cfg_ready, cfg_valid, cfg_last, stall_en;
  logic [7:0] paddr, cfg_octet, l, m, f, s, n, st, did, km1;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, cfg_index;
  logic [2:0] cfg_lane;
  int err_total, comparisons, rx_n, idx_c, lane_c, w, seen;
  int fmt8[6] = '{0, 1, 2, 3, 9, 10};
  int fmt64[6] = '{4, 5, 6, 7, 8, 14};

  ilas_link_config_generator ilas_link_config_generator_i (.core_clk(core_clk),
    .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ilas_start(ilas_start), .cfg_ready(cfg_ready), .cfg_valid(cfg_valid),
    .cfg_octet(cfg_octet), .cfg_index(cfg_index), .cfg_lane(cfg_lane), .cfg_last(cfg_last));
  cfg_sink cfg_sink_i (.core_clk(core_clk), .arst_n(arst_n), .stall_en(stall_en),
    .cfg_ready(cfg_ready));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task tally_and_finish;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer: setup, then access until pready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // expected mode figures for the 8b/10b formats
  task set_mode(input int sel);
    case (sel)
      0: {l, m, f, s, n, st} = {8'd8, 8'd8, 8'd8, 8'd5, 8'd12, 8'd4};
      1: {l, m, f, s, n, st} = {8'd6, 8'd4, 8'd2, 8'd2, 8'd12, 8'd16};
      2: {l, m, f, s, n, st} = {8'd4, 8'd4, 8'd1, 8'd1, 8'd8, 8'd32};
      3: {l, m, f, s, n, st} = {8'd4, 8'd4, 8'd5, 8'd4, 8'd10, 8'd32};
      9: {l, m, f, s, n, st} = {8'd8, 8'd4, 8'd1, 8'd2, 8'd8, 8'd32};
      default: {l, m, f, s, n, st} = {8'd8, 8'd8, 8'd5, 8'd4, 8'd10, 8'd32};
    endcase
  endtask

  function automatic logic [7:0] exp_octet(input logic [7:0] ln, input int idx);
    logic [7:0] cs;
    cs = did + scr + (l - 1) + (f - 1) + km1 + (m - 1) + (n - 1) + 1 + (n - 1) + 1 + (s - 1) + ln;
    case (idx)
      0: return did;
      2: return ln;
      3: return {scr, 2'b00, l[4:0] - 5'd1};
      4: return f - 1;
      5: return km1;
      6: return m - 1;
      7: return n - 1;
      8: return {3'b001, n[4:0] - 5'd1};
      9: return {3'b001, s[4:0] - 5'd1};
      13: return cs;
      default: return 8'h00;
    endcase
  endfunction

  // disable, program format and ids, then enable as asked
  task link_cfg(input logic [3:0] sel, input logic en);
    scr = 1'($urandom);
    did = 8'($urandom);
    km1 = 8'(st * (1 + $urandom % (256 / st)) - 1);
    apb(1'b1, CTRL_OFS, 32'h0);
    apb(1'b1, CTRL_OFS, {27'h0, scr, sel});
    apb(1'b1, CFG_OFS, {16'h0, km1, did});
    apb(1'b1, CTRL_OFS, {26'h0, en, scr, sel});
  endtask

  task pulse_start;
    @(posedge core_clk);
    ilas_start <= 1'b1;
    @(posedge core_clk);
    ilas_start <= 1'b0;
  endtask

  // a start that must be ignored: no octet for 20 cycles
  task refused(input logic [3:0] sel, input logic en);
    link_cfg(sel, en);
    pulse_start();
    seen = 0;
    repeat (20) begin
      @(posedge core_clk);
      if (cfg_valid !== 1'b0)
        seen++;
    end
    chk("quiet", 0, seen);
  endtask

  // stream monitor: every accepted octet against the expected field
  always @(posedge core_clk) begin
    if (arst_n === 1'b1 && cfg_valid === 1'b1 && cfg_ready === 1'b1) begin
      chk("cfg_octet", exp_octet(8'(lane_c), idx_c), cfg_octet);
      chk("cfg_index", idx_c, cfg_index);
      chk("cfg_lane", lane_c, cfg_lane);
      chk("cfg_last", lane_c == l - 1 && idx_c == 13, cfg_last);
      rx_n++;
      idx_c = (idx_c == 13) ? 0 : idx_c + 1;
      lane_c = (idx_c == 0) ? lane_c + 1 : lane_c;
    end
  end

  initial begin
    {arst_n, psel, penable, pwrite, ilas_start, stall_en} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    {err_total, comparisons, rx_n, idx_c, lane_c} = '0;
    set_mode(0);
    void'($urandom(32'haf52));
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl_reset", 32'h0, rd);
    apb(1'b0, CFG_OFS, 32'h0);
    chk("cfg_reset", 32'h0300, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped_err", 1, e);
    apb(1'b1, PARAM_OFS, 32'h0);
    chk("ro_write_err", 1, e);
    pstrb <= 4'h1;
    apb(1'b1, CFG_OFS, 32'h0000ffaa);
    pstrb <= 4'hf;
    apb(1'b0, CFG_OFS, 32'h0);
    chk("strobe_cfg", 32'h000003aa, rd);
    // every 8b/10b format, receiver stalling on every other run
    foreach (fmt8[i]) begin
      set_mode(fmt8[i]);
      link_cfg(4'(fmt8[i]), 1'b1);
      apb(1'b0, PARAM_OFS, 32'h0);
      chk("param", {n[4:0] - 5'd1, n[4:0] - 5'd1, 1'b0, s[2:0] - 3'd1, f[3:0], m[3:0], l[3:0]},
          rd[25:0]);
      apb(1'b1, CFG_OFS, ~{16'h0, km1, did});
      apb(1'b0, CFG_OFS, 32'h0);
      chk("cfg_locked", {km1, did}, rd);
      stall_en <= 1'(i);
      {rx_n, idx_c, lane_c} = '0;
      pulse_start();
      apb(1'b0, STAT_OFS, 32'h0);
      chk("stat_busy", 1, rd[24]);
      chk("stat_sum", exp_octet(8'h00, 13), rd[23:16]);
      repeat (5) @(posedge core_clk);
      pulse_start();
      for (w = 0; w < 3000 && !(rx_n == 14 * l && cfg_valid === 1'b0); w++)
        @(posedge core_clk);
      chk("octet_count", 14 * l, rx_n);
      if (w == 3000) begin
        err_total++;
        tally_and_finish();
      end
    end
    // 64b/66b formats: fixed frame count and no sequence
    foreach (fmt64[i]) begin
      refused(4'(fmt64[i]), 1'b1);
      apb(1'b0, STAT_OFS, 32'h0);
      chk("stat_k", (fmt64[i] <= 6) ? 128 : 256, rd[9:0]);
    end
    refused(4'd2, 1'b0);
    refused(4'd11, 1'b1);
    apb(1'b0, PARAM_OFS, 32'h0);
    chk("invalid_flag", 1, rd[27]);
    tally_and_finish();
  end
endmodule
`default_nettype wire
